// file: mpc_regs.vh
`ifndef MPC_REGS_VH
`define MPC_REGS_VH
// correction method encodings
`define MPC_CORR_NONE    2'b00
`define MPC_CORR_MANUAL  2'b01
`define MPC_CORR_DEADT   2'b10
`define MPC_CORR_HALF    2'b11
// generator defaults after reset
`define MPC_RST_PRESCALE 2'b00
`define MPC_RST_WIDTH    16'h0000
`define MPC_RST_MODULUS  16'h0001
// software output control of independent pins settles within this many clocks
`define MPC_SW_LAT_CYC   3
`endif

// file: mpc_core.v
`timescale 1ns/10ps
`include "mpc_regs.vh"

// How it works
// [RULE_01] current-sense low picks even width register, high picks odd one
// [RULE_02] method 10 samples sense in deadtime; 11 at half cycle or cycle end
// [RULE_03] sampled sense is buffered, applied only from next PWM period
// [RULE_04] first enable with automatic correction uses odd registers
// [RULE_05] top invert makes 0,2,4 active low; bottom invert makes 1,3,5 active low
// [RULE_06] independent mode: software enable drives channel from software level bit
// [RULE_07] complementary: even software bits feed deadtime, toggles insert deadtime
// [RULE_08] odd level set gives complement of even partner, clear keeps odd inactive
// [RULE_09] inversion still applies under software control, visible within 3 clocks
// [RULE_10] generator keeps running; software release takes effect at next cycle; only complementary pairs wait, independent pins release at the next clock
// [RULE_11] software control and deadtime work with generator disabled
// [RULE_12] load okay copies prescale, modulus, widths into buffers at reload
// [RULE_13] software sets load okay; hardware clears it after the load
// [RULE_14] reload rate field gates reloads to every Nth opportunity, N 1..16
// [RULE_15] center-aligned half bit adds mid-cycle opportunities at count equal modulus
// [RULE_16] modulus loaded at half cycle forces counter to modulus minus one
// [RULE_17] reload flag set at every opportunity; enable gates interrupt request
// [RULE_18] enabling sets reload flag; first enable with load okay loads at once
// [RULE_19] first enable without load okay loads divisor one and zero width
// [RULE_20] disable tri-states unless software control, clears counter, zero outputs
// [RULE_21] fault input one disables pins chosen by four mapping bits per pin
// [RULE_22] fault only masks pins, generator runs, detection active while disabled
// [RULE_23] method field: 00 none, 01 manual, 10 deadtime sampling, 11 half sampling
// [RULE_24] manual select bit per pair buffered, applied at each cycle end
// [RULE_25] deadtime input change holds both pair outputs inactive for programmed count
module mpc_core #(
  parameter DW = 16,
  parameter DTW = 8
) (
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          generator_enable,
  input  wire          complementary,
  input  wire          center_aligned,
  input  wire          half_reload,
  input  wire [1:0]    correction_method_select,
  input  wire [2:0]    manual_select_bit,
  input  wire [2:0]    current_sense_pin,
  input  wire          top_invert,
  input  wire          bottom_invert,
  input  wire [5:0]    sw_output_enable,
  input  wire [5:0]    sw_output_level,
  input  wire          load_okay_set,
  input  wire [3:0]    reload_rate_field,
  input  wire          reload_flag_clr,
  input  wire          reload_irq_enable,
  input  wire [1:0]    prescale_select,
  input  wire [DW-1:0] modulus_register,
  input  wire [6*DW-1:0] pulse_width_register,
  input  wire [DTW-1:0] deadtime_count,
  input  wire [3:0]    fault_in,
  input  wire [23:0]   fault_map,
  input  wire [5:0]    fault_pin_disable,
  output reg           load_okay,
  output reg           reload_flag,
  output reg           reload_irq,
  output reg  [5:0]    pwm_out,
  output reg  [5:0]    pwm_oe
);

  // ************************************************************
  // synchronise sense and fault pins
  // ************************************************************
  reg  [6:0] pin_s1;
  reg  [6:0] pin_s2;
  reg  [6:0] pin_s3;
  reg  [6:0] pin_q;
  wire [6:0] pin_raw = {fault_in, current_sense_pin};

  // three stages; a change counts once stages two and three agree
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_s1 <= 7'h00;
      pin_s2 <= 7'h00;
      pin_s3 <= 7'h00;
      pin_q  <= 7'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q  <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
    end
  end
  wire [2:0] sense = pin_q[2:0];
  wire [3:0] fault = pin_q[6:3];

  // ************************************************************
  // prescaler, counter and reload control
  // ************************************************************
  reg  [1:0]    buf_prescale_select;
  reg  [DW-1:0] buf_mod;
  reg  [6*DW-1:0] buf_val;
  reg  [6:0]    pre_cnt;
  reg  [DW-1:0] cnt;
  reg           cnt_down;
  reg  [3:0]    rate_cnt;
  reg           en_d;
  reg           enabled_once;
  wire [6:0]    pre_div = (7'h01 << (2 * buf_prescale_select)) - 7'h01;
  wire          tick = generator_enable && (pre_cnt >= pre_div);
  wire          at_mod = (cnt == buf_mod);
  wire          cyc_start = tick && (center_aligned ? (cnt_down && cnt <= 16'h0001) : at_mod);
  wire          half_pt = tick && center_aligned && !cnt_down && at_mod;
  wire          opp = cyc_start || (half_pt && half_reload); // [RULE_15]
  wire          en_rise = generator_enable && !en_d;
  wire          rate_hit = (rate_cnt == reload_rate_field); // [RULE_14]
  wire          do_load = (opp && rate_hit && load_okay) || (en_rise && load_okay);
  wire          first_blank = en_rise && !enabled_once && !load_okay;

  // counter clears and stops while disabled
  always @(posedge ref_clk) begin
    if (sys_rst || !generator_enable) begin // [RULE_20]
      pre_cnt  <= 7'h00;
      cnt      <= {DW{1'b0}};
      cnt_down <= 1'b0;
    end else if (do_load && half_pt) begin
      pre_cnt  <= 7'h00;
      cnt      <= modulus_register - 1'b1; // [RULE_16]
      cnt_down <= 1'b1;
    end else if (tick) begin
      pre_cnt <= 7'h00;
      if (center_aligned) begin
        if (!cnt_down && at_mod) begin
          cnt_down <= 1'b1;
          cnt      <= cnt - 1'b1;
        end else if (cnt_down && cnt <= 16'h0001) begin
          cnt_down <= 1'b0;
          cnt      <= cnt + 1'b1;
        end else begin
          cnt <= cnt_down ? cnt - 1'b1 : cnt + 1'b1;
        end
      end else begin
        cnt <= at_mod ? {DW{1'b0}} : cnt + 1'b1;
      end
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // buffers, load okay, reload flag and rate divider
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      buf_prescale_select     <= `MPC_RST_PRESCALE;
      buf_mod      <= `MPC_RST_MODULUS;
      buf_val      <= {6{`MPC_RST_WIDTH}};
      load_okay    <= 1'b0;
      reload_flag  <= 1'b0;
      reload_irq   <= 1'b0;
      rate_cnt     <= 4'h0;
      en_d         <= 1'b0;
      enabled_once <= 1'b0;
    end else begin
      en_d <= generator_enable;
      if (en_rise)
        enabled_once <= 1'b1;
      if (do_load) begin // [RULE_12]
        buf_prescale_select <= prescale_select;
        buf_mod  <= modulus_register;
        buf_val  <= pulse_width_register;
      end else if (first_blank) begin // [RULE_19]
        buf_prescale_select <= `MPC_RST_PRESCALE;
        buf_val  <= {6{`MPC_RST_WIDTH}};
      end
      // set wins over the hardware clear
      if (load_okay_set)
        load_okay <= 1'b1; // [RULE_13]
      else if (do_load)
        load_okay <= 1'b0; // [RULE_13]
      if (opp)
        rate_cnt <= rate_hit ? 4'h0 : rate_cnt + 4'h1;
      else if (en_rise)
        rate_cnt <= 4'h0;
      // flag kept while disabled; set wins over clear
      if (opp || en_rise)
        reload_flag <= 1'b1; // [RULE_17] [RULE_18]
      else if (reload_flag_clr)
        reload_flag <= 1'b0;
      reload_irq <= ((opp || en_rise) || (reload_flag && !reload_flag_clr))
                    && reload_irq_enable; // [RULE_17]
    end
  end

  // ************************************************************
  // per-pair correction, generator, deadtime and pins
  // ************************************************************
  // each pair drives its own slice of these three vectors
  wire [5:0] gen_out;
  wire [5:0] pin_pre;
  wire [5:0] pin_oe_pre;
  wire [5:0] fault_dis;
  wire       auto_corr = correction_method_select[1];
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : chan
      // pin is masked when any mapped enabled fault is high
      assign fault_dis[g] = |(fault_map[4*g+3:4*g] & fault & ~fault_pin_disable[3:0]); // [RULE_21]
    end
    for (g = 0; g < 3; g = g + 1) begin : pair
      reg           samp;
      reg           sel;
      reg           sw_sel;
      reg           dt_in;
      reg           dt_prev;
      reg [DTW-1:0] dt_cnt;
      reg [1:0]     gen_pr;
      reg [1:0]     pin_pr;
      reg [1:0]     oe_pr;
      wire [DW-1:0] w_even = buf_val[2*g*DW +: DW];
      wire [DW-1:0] w_odd  = buf_val[(2*g+1)*DW +: DW];
      wire [DW-1:0] width  = sel ? w_odd : w_even; // [RULE_01]
      wire          gen_a  = center_aligned ? (cnt >= buf_mod - ((width >> 1) & buf_mod))
                                            : (cnt < width);
      wire          sw_on  = sw_output_enable[2*g];
      wire          dt_src = sw_sel ? sw_output_level[2*g] : gen_out[2*g]; // [RULE_07]
      wire          in_dt  = (dt_cnt != {DTW{1'b0}});
      // one driver per slice keeps the shared vectors single-sourced
      assign gen_out[2*g+1:2*g]    = gen_pr;
      assign pin_pre[2*g+1:2*g]    = pin_pr;
      assign pin_oe_pre[2*g+1:2*g] = oe_pr;
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          samp    <= 1'b1;
          sel     <= 1'b0;
          sw_sel  <= 1'b0;
          dt_in   <= 1'b0;
          dt_prev <= 1'b0;
          dt_cnt  <= {DTW{1'b0}};
        end else begin
          // sample the sense level per method
          if (correction_method_select == `MPC_CORR_DEADT && in_dt) // [RULE_02] [RULE_23]
            samp <= sense[g];
          else if (correction_method_select == `MPC_CORR_HALF &&
                   (center_aligned ? half_pt : cyc_start)) // [RULE_02]
            samp <= sense[g];
          // fresh enable: odd registers under automatic correction
          if (en_rise && auto_corr) begin
            samp <= 1'b1; // [RULE_04]
            sel  <= 1'b1; // [RULE_04]
          end else if (cyc_start) begin // [RULE_03] [RULE_24]
            case (correction_method_select)
              `MPC_CORR_NONE:   sel <= 1'b0;
              `MPC_CORR_MANUAL: sel <= manual_select_bit[g];
              default:          sel <= samp;
            endcase
          end
          // software takes over at once, releases at next cycle
          if (sw_on)
            sw_sel <= 1'b1; // [RULE_11]
          else if (cyc_start || !generator_enable)
            sw_sel <= 1'b0; // [RULE_10]
          dt_in   <= dt_src;
          dt_prev <= dt_in;
          if (dt_in != dt_prev)
            dt_cnt <= deadtime_count; // [RULE_25]
          else if (in_dt)
            dt_cnt <= dt_cnt - 1'b1;
        end
      end
      // generator output zero when disabled; keeps running otherwise
      always @(posedge ref_clk) begin
        if (sys_rst || !generator_enable)
          gen_pr <= 2'b00; // [RULE_20]
        else
          gen_pr <= {~gen_a, gen_a};
      end
      // pin selection: complementary with deadtime, or independent
      always @* begin
        if (complementary) begin
          pin_pr[0] = dt_prev && !in_dt;
          pin_pr[1] = !dt_prev && !in_dt &&
                      (!sw_sel || sw_output_level[2*g+1]); // [RULE_08]
        end else begin
          pin_pr[0] = sw_output_enable[2*g] ? sw_output_level[2*g]
                                            : gen_out[2*g]; // [RULE_06]
          pin_pr[1] = sw_output_enable[2*g+1] ? sw_output_level[2*g+1]
                                              : gen_out[2*g+1]; // [RULE_06]
        end
        // in pair mode the even enable governs both pins
        oe_pr[0] = generator_enable || sw_output_enable[2*g];
        oe_pr[1] = generator_enable ||
                   sw_output_enable[complementary ? 2*g : 2*g+1];
      end
    end
  endgenerate

  // registered pins: fault masks, then polarity
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pwm_out <= 6'h00;
      pwm_oe  <= 6'h00;
    end else begin
      pwm_out <= (pin_pre & ~fault_dis) ^
                 {bottom_invert, top_invert, bottom_invert, top_invert,
                  bottom_invert, top_invert}; // [RULE_05] [RULE_09] [RULE_22]
      pwm_oe  <= pin_oe_pre; // [RULE_20]
    end
  end

endmodule

// file: mpc_monitor.sv
`timescale 1ns/10ps
// ****
// checker on the core ports
// ****
module mpc_monitor (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        generator_enable,
  input wire        complementary,
  input wire        top_invert,
  input wire        bottom_invert,
  input wire [5:0]  sw_output_enable,
  input wire [5:0]  sw_output_level,
  input wire        load_okay_set,
  input wire        reload_flag_clr,
  input wire        reload_irq_enable,
  input wire [3:0]  fault_in,
  input wire [23:0] fault_map,
  input wire [5:0]  fault_pin_disable,
  input wire        load_okay,
  input wire        reload_flag,
  input wire        reload_irq,
  input wire [5:0]  pwm_out,
  input wire [5:0]  pwm_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // steady software drive of the first pair
  sequence sw0_s;
    !complementary && sw_output_enable[0] && fault_map[3:0] == 4'h0
    && $stable(sw_output_level[0]) && $stable(top_invert);
  endsequence
  sequence sw1_s;
    !complementary && sw_output_enable[1] && fault_map[7:4] == 4'h0
    && $stable(sw_output_level[1]) && $stable(bottom_invert);
  endsequence
  // fault 0 mapped onto pin 0, polarity steady
  sequence flt0_s;
    fault_in[0] && fault_map[3:0] == 4'h1 && !fault_pin_disable[0] && $stable(top_invert);
  endsequence
  // assertions on the outputs
  sw_top_a: assert property (
    sw0_s [*4] |-> pwm_oe[0] && pwm_out[0] == (sw_output_level[0] ^ top_invert))
    else $error("top channel wrong");
  sw_bot_a: assert property (
    sw1_s [*4] |-> pwm_oe[1] && pwm_out[1] == (sw_output_level[1] ^ bottom_invert))
    else $error("bottom channel wrong");
  load_set_a: assert property (
    load_okay_set |=> load_okay)
    else $error("load okay not set");
  load_okay_hold_a: assert property (
    !generator_enable [*2] ##0 load_okay |=> load_okay)
    else $error("load okay lost");
  en_flag_a: assert property (
    $rose(generator_enable) |=> reload_flag)
    else $error("no flag on enable");
  flag_hold_a: assert property (
    reload_flag && !reload_flag_clr |=> reload_flag)
    else $error("flag dropped");
  flag_clr_a: assert property (
    !generator_enable [*2] ##0 reload_flag_clr |=> !reload_flag)
    else $error("flag not cleared");
  irq_gate_a: assert property (
    !reload_irq_enable [*2] |-> !reload_irq)
    else $error("irq while masked");
  irq_on_a: assert property (
    (reload_flag && reload_irq_enable) [*2] |-> reload_irq)
    else $error("irq missing");
  oe_off_a: assert property (
    (!generator_enable && sw_output_enable == 6'h00) [*3] |-> pwm_oe == 6'h00)
    else $error("pins driven");
  // a masked pin sits at its inactive level, which follows the polarity bit
  fault_mask_a: assert property (
    flt0_s [*7] |-> pwm_out[0] == top_invert)
    else $error("fault ignored");
endmodule
bind mpc_core mpc_monitor i_mon (.ref_clk, .sys_rst, .generator_enable, .complementary,
  .top_invert, .bottom_invert, .sw_output_enable, .sw_output_level, .load_okay_set,
  .reload_flag_clr, .reload_irq_enable, .fault_in, .fault_map, .fault_pin_disable,
  .load_okay, .reload_flag, .reload_irq, .pwm_out, .pwm_oe);

// file: mpc_bridge.sv
`timescale 1ns/10ps
// ****
// half-bridge current sense model
// ****
module mpc_bridge (
  input  wire       ref_clk,
  input  wire [2:0] current_dir,
  output reg  [2:0] current_sense_pin
);
  // sense pin low for positive current, high for negative
  always @(posedge ref_clk) begin
    current_sense_pin <= current_dir;
  end
endmodule

// file: test_motor_pwm_correction_load_ctrl.sv
`timescale 1ns/10ps
// ****
// bench
// ****
module test_motor_pwm_correction_load_ctrl;
  reg         ref_clk = 1'b0, sys_rst = 1'b1, generator_enable = 1'b0, complementary = 1'b0;
  reg         center_aligned = 1'b0, half_reload = 1'b0, top_invert = 1'b0, bottom_invert = 1'b0;
  reg         load_okay_set = 1'b0, reload_flag_clr = 1'b0, reload_irq_enable = 1'b0;
  reg  [1:0]  correction_method_select = 2'h0;
  reg  [2:0]  current_dir = 3'h0, manual_select_bit = 3'h0;
  reg  [3:0]  reload_rate_field = 4'h0, fault_in = 4'h0;
  reg  [5:0]  sw_output_enable = 6'h00, sw_output_level = 6'h00, fault_pin_disable = 6'h00;
  reg  [23:0] fault_map = 24'h000000;
  wire [2:0]  current_sense_pin;
  wire [5:0]  pwm_out, pwm_oe;
  wire        load_okay, reload_flag, reload_irq;
  reg         x;
  integer     fail_count = 0, n_checks = 0, i, k;
  // clock
  always #12.5 ref_clk = ~ref_clk;
  mpc_core i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .generator_enable(generator_enable),
    .complementary(complementary), .center_aligned(center_aligned), .half_reload(half_reload),
    .correction_method_select(correction_method_select), .manual_select_bit(manual_select_bit),
    .current_sense_pin(current_sense_pin), .top_invert(top_invert), .bottom_invert(bottom_invert),
    .sw_output_enable(sw_output_enable), .sw_output_level(sw_output_level),
    .load_okay_set(load_okay_set), .reload_rate_field(reload_rate_field),
    .reload_flag_clr(reload_flag_clr), .reload_irq_enable(reload_irq_enable),
    .prescale_select(2'h0), .modulus_register(16'h0010),
    .pulse_width_register({{4{16'h0004}}, 16'h0008, 16'h0004}),
    .deadtime_count(8'h02), .fault_in(fault_in), .fault_map(fault_map),
    .fault_pin_disable(fault_pin_disable), .load_okay(load_okay), .reload_flag(reload_flag),
    .reload_irq(reload_irq), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  mpc_bridge i_bridge (.ref_clk(ref_clk), .current_dir(current_dir),
    .current_sense_pin(current_sense_pin));
  // compare and count
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  // wait n edges then settle
  task look(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  // count high cycles of channel 0 over two edge-aligned periods
  task count_on(output integer c);
    begin
      c = 0;
      repeat (34) begin
        look(1);
        c = c + pwm_out[0];
      end
    end
  endtask
  // verdict
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    look(1);
    chk({3'h0, load_okay, reload_flag, reload_irq, 2'h0}, 8'h00);
    chk({2'h0, pwm_oe}, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge ref_clk);
      sw_output_enable <= 6'h03;
      top_invert <= i[0];
      bottom_invert <= i[1];
      sw_output_level <= {4'h0, i[0], i[1]};
      x = i[0] ^ i[1];
      look(3);
      chk({4'h0, pwm_oe[1:0], pwm_out[1:0]}, {4'h0, 2'b11, x, x});
      look(1);
    end
    @(posedge ref_clk);
    top_invert <= 1'b0;
    sw_output_level <= 6'h01;
    fault_map <= 24'h000001;
    fault_in <= 4'h1;
    look(8);
    chk({7'h00, pwm_out[0] & pwm_oe[0]}, 8'h00);
    @(posedge ref_clk);
    fault_pin_disable <= 6'h01;
    look(8);
    chk({7'h00, pwm_out[0]}, 8'h01);
    @(posedge ref_clk);
    fault_in <= 4'h0;
    sw_output_enable <= 6'h00;
    look(3);
    chk({2'h0, pwm_oe}, 8'h00);
    chk({7'h00, load_okay}, 8'h00);
    @(posedge ref_clk);
    load_okay_set <= 1'b1;
    @(posedge ref_clk);
    load_okay_set <= 1'b0;
    #1;
    chk({7'h00, load_okay}, 8'h01);
    @(posedge ref_clk);
    generator_enable <= 1'b1;
    reload_irq_enable <= 1'b1;
    complementary <= 1'b1;
    center_aligned <= 1'b1;
    half_reload <= 1'b1;
    correction_method_select <= 2'b11;
    reload_rate_field <= 4'h1;
    current_dir <= 3'h5;
    look(1);
    chk({6'h00, load_okay, reload_flag}, 8'h01);
    look(2);
    chk({7'h00, reload_irq}, 8'h01);
    @(posedge ref_clk);
    reload_flag_clr <= 1'b1;
    @(posedge ref_clk);
    reload_flag_clr <= 1'b0;
    i = 0;
    look(2);
    while (reload_flag !== 1'b1 && i < 400) begin
      look(1);
      i = i + 1;
    end
    chk({7'h00, reload_flag}, 8'h01);
    @(posedge ref_clk);
    generator_enable <= 1'b0;
    look(4);
    chk({1'h0, reload_flag, pwm_oe}, 8'h40);
    @(posedge ref_clk);
    reload_flag_clr <= 1'b1;
    @(posedge ref_clk);
    reload_flag_clr <= 1'b0;
    look(1);
    chk({7'h00, reload_flag}, 8'h00);
    // re-enable without load okay: manual pick of even, then odd width
    @(posedge ref_clk);
    generator_enable <= 1'b1;
    complementary <= 1'b0;
    center_aligned <= 1'b0;
    correction_method_select <= 2'b01;
    look(40);
    chk({2'h0, pwm_oe}, 8'h3f);
    count_on(k);
    chk(k[7:0], 8'h08);
    @(posedge ref_clk);
    manual_select_bit <= 3'h1;
    look(40);
    count_on(k);
    chk(k[7:0], 8'h10);
    test_done;
  end
endmodule
